// ### src/cds_defs.svh
// constants for the card deactivation and fault supervisor
`ifndef CDS_DEFS_SVH
`define CDS_DEFS_SVH

// timing
`define CDS_CLK_PERIOD_NS   8
`define CDS_OSC_PERIOD_NS   390
`define CDS_HALF_UNIT_OSC   32
`define CDS_HALF_UNIT_CYC   \
   ((`CDS_HALF_UNIT_OSC * `CDS_OSC_PERIOD_NS + `CDS_CLK_PERIOD_NS - 1) \
    / `CDS_CLK_PERIOD_NS)
`define CDS_OVL_FILTER_NS   20000
`define CDS_OVL_FILTER_CYC  \
   ((`CDS_OVL_FILTER_NS + `CDS_CLK_PERIOD_NS - 1) / `CDS_CLK_PERIOD_NS)
`define CDS_DEBOUNCE_NS     8000000
`define CDS_DEBOUNCE_CYC    (`CDS_DEBOUNCE_NS / `CDS_CLK_PERIOD_NS)

// sequencer steps in half units after card reset falls
`define CDS_STEP_CLK_HOLD   4'h1
`define CDS_STEP_LINES_LOW  4'h2
`define CDS_STEP_SUPPLY_OFF 4'h3
`define CDS_STEP_GROUND     4'ha

// register offsets
`define CDS_REG_STATUS      4'h0
`define CDS_REG_CLEAR       4'h4
`define CDS_REG_ENABLE      4'h8
`define CDS_REG_STATE       4'hc

// event bits
`define CDS_EV_DONE         0
`define CDS_EV_FAULT        1
`define CDS_EV_INSERT       2
`define CDS_EV_EXTRACT      3
`define CDS_EV_W            4

`endif

// ### src/cds_pkg.sv
// types for the card deactivation and fault supervisor
package cds_pkg;

   typedef enum logic [1:0] {
      CDS_IDLE   = 2'b00,
      CDS_ACTIVE = 2'b01,
      CDS_DEACT  = 2'b10
   } cds_state_t;

   // card contact controls, high means enabled
   typedef struct packed {
      logic rst_en;
      logic clk_run;
      logic io_en;
      logic vcc_en;
      logic boost_en;
      logic gnd;
      logic osc_fast;
   } cds_contacts_t;

endpackage : cds_pkg

// ### src/cds_supervisor.sv
// card session deactivation sequencer with fault and presence supervision
`timescale 1ns/1ps
`default_nettype none
`include "cds_defs.svh"

module cds_supervisor #(
   parameter int DEBOUNCE_CYC = `CDS_DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset,
   // host and card pins
   input  wire logic              i_session_request_n,
   input  wire logic              i_card_presence,
   input  wire logic              i_card_presence_n,
   // analogue monitors
   input  wire logic              i_supply_overload,
   input  wire logic              i_host_supply_low,
   input  wire logic              i_converter_fault,
   input  wire logic              i_overheat,
   input  wire logic              i_supply_inactive,
   // register port
   input  wire logic [3:0]        i_addr,
   input  wire logic [31:0]       i_wr_data,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rd_data,
   // outputs
   output cds_pkg::cds_contacts_t o_contacts,
   output logic                   o_fault_status_n,
   output logic                   o_por_pulse,
   output logic                   o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   localparam int HALF_CYC = `CDS_HALF_UNIT_CYC;
   localparam int OVL_CYC  = `CDS_OVL_FILTER_CYC;

   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic       sreq_n_s;
   logic       present_s;
   logic       ovl_s;
   logic       host_low_s;
   logic       conv_s;
   logic       heat_s;
   logic       vcc_off_s;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sync1_r <= 7'h50;
         sync2_r <= 7'h50;
      end else begin
         sync1_r <= {i_session_request_n, i_card_presence, i_card_presence_n,
                     i_supply_overload, i_host_supply_low, i_converter_fault,
                     i_overheat};
         sync2_r <= sync1_r;
      end
   end

   // reset value of the inputs is harmless: request high, no card
   always_comb begin
      sreq_n_s   = sync2_r[6];
      present_s  = sync2_r[5] | ~sync2_r[4];
      ovl_s      = sync2_r[3];
      host_low_s = sync2_r[2];
      conv_s     = sync2_r[1];
      heat_s     = sync2_r[0];
   end

   logic vcc1_r;
   logic vcc2_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         vcc1_r <= 1'b1;
         vcc2_r <= 1'b1;
      end else begin
         vcc1_r <= i_supply_inactive;
         vcc2_r <= vcc1_r;
      end
   end

   assign vcc_off_s = vcc2_r;

   ////////////////////////////////////////////////////////////////////////
   // presence debounce and overload filter

   logic [19:0] deb_cnt_r;
   logic        deb_r;
   logic        deb_nxt;

   always_comb begin
      deb_nxt = deb_r;
      if (!present_s) begin
         deb_nxt = 1'b0;
      end else if (deb_cnt_r == 20'(DEBOUNCE_CYC - 1)) begin
         deb_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         deb_cnt_r <= 20'h0;
         deb_r     <= 1'b0;
      end else begin
         deb_r <= deb_nxt;
         if (!present_s || deb_r) begin
            deb_cnt_r <= 20'h0;
         end else begin
            deb_cnt_r <= deb_cnt_r + 20'h1;
         end
      end
   end

   logic [11:0] ovl_cnt_r;
   logic        ovl_flt;

   // short current spikes never reach the full count
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !ovl_s) begin
         ovl_cnt_r <= 12'h0;
      end else if (!ovl_flt) begin
         ovl_cnt_r <= ovl_cnt_r + 12'h1;
      end
   end

   assign ovl_flt = (ovl_cnt_r == 12'(OVL_CYC));

   ////////////////////////////////////////////////////////////////////////
   // session sequencer

   cds_pkg::cds_state_t state_r;
   cds_pkg::cds_state_t state_nxt;
   logic [3:0]          step_r;
   logic [3:0]          step_nxt;
   logic [10:0]         half_cnt_r;
   logic                half_tick;
   logic                fault_r;
   logic                fault_nxt;
   logic                sess_fault;

   assign half_tick = (half_cnt_r == 11'(HALF_CYC - 1));

   // overload and heat are only looked at while the card is powered
   assign sess_fault = ovl_flt | ~present_s | host_low_s | conv_s
                       | heat_s;

   always_comb begin
      state_nxt = state_r;
      step_nxt  = step_r;
      fault_nxt = fault_r;
      case (state_r)
         cds_pkg::CDS_IDLE: begin
            if (sreq_n_s) begin
               fault_nxt = 1'b0;
            end else if (deb_r && !fault_r && !host_low_s) begin
               state_nxt = cds_pkg::CDS_ACTIVE;
            end
         end
         cds_pkg::CDS_ACTIVE: begin
            if (sess_fault) begin
               fault_nxt = 1'b1;
               state_nxt = cds_pkg::CDS_DEACT;
               step_nxt  = 4'h0;
            end else if (sreq_n_s) begin
               state_nxt = cds_pkg::CDS_DEACT;
               step_nxt  = 4'h0;
            end
         end
         cds_pkg::CDS_DEACT: begin
            // requests are not looked at until the end
            if (step_r == `CDS_STEP_GROUND) begin
               if (vcc_off_s) begin
                  state_nxt = cds_pkg::CDS_IDLE;
               end
            end else if (half_tick) begin
               step_nxt = step_r + 4'h1;
            end
            if (!present_s) begin
               fault_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = cds_pkg::CDS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_r    <= cds_pkg::CDS_IDLE;
         step_r     <= 4'h0;
         fault_r    <= 1'b0;
         half_cnt_r <= 11'h0;
      end else begin
         state_r <= state_nxt;
         step_r  <= step_nxt;
         fault_r <= fault_nxt;
         if (state_nxt != cds_pkg::CDS_DEACT || state_r != state_nxt
             || half_tick) begin
            half_cnt_r <= 11'h0;
         end else begin
            half_cnt_r <= half_cnt_r + 11'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // contact drive, from the next state so the edges land on time

   function automatic cds_pkg::cds_contacts_t contacts_of(
      input cds_pkg::cds_state_t st,
      input logic [3:0]          stp
   );
      cds_pkg::cds_contacts_t c;
      c = '0;
      c.gnd = 1'b1;
      case (st)
         cds_pkg::CDS_ACTIVE: begin
            c = '1;
            c.gnd = 1'b0;
         end
         cds_pkg::CDS_DEACT: begin
            c.rst_en   = 1'b0;
            c.clk_run  = (stp < `CDS_STEP_CLK_HOLD);
            c.io_en    = (stp < `CDS_STEP_LINES_LOW);
            c.vcc_en   = (stp < `CDS_STEP_SUPPLY_OFF);
            c.boost_en = (stp < `CDS_STEP_GROUND);
            c.gnd      = (stp >= `CDS_STEP_GROUND);
            c.osc_fast = 1'b1;
         end
         default: begin
            c.osc_fast = 1'b0;
         end
      endcase
      return c;
   endfunction : contacts_of

   logic host_low_d_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_contacts       <= contacts_of(cds_pkg::CDS_IDLE, 4'h0);
         o_fault_status_n <= 1'b0;
         o_por_pulse      <= 1'b0;
         host_low_d_r     <= 1'b0;
      end else begin
         o_contacts       <= contacts_of(state_nxt, step_nxt);
         o_fault_status_n <= deb_nxt & ~fault_nxt;
         host_low_d_r     <= host_low_s;
         o_por_pulse      <= host_low_s & ~host_low_d_r
                             & (state_r == cds_pkg::CDS_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers and interrupt

   logic [`CDS_EV_W-1:0] ev_stat_r;
   logic [`CDS_EV_W-1:0] ev_en_r;
   logic [`CDS_EV_W-1:0] ev_set;
   logic [`CDS_EV_W-1:0] ev_clr;

   always_comb begin
      ev_set = '0;
      ev_set[`CDS_EV_DONE]    = (state_r == cds_pkg::CDS_DEACT)
                                && (state_nxt == cds_pkg::CDS_IDLE);
      ev_set[`CDS_EV_FAULT]   = fault_nxt & ~fault_r;
      ev_set[`CDS_EV_INSERT]  = deb_nxt & ~deb_r;
      ev_set[`CDS_EV_EXTRACT] = ~deb_nxt & deb_r;
      ev_clr = (i_wr && i_addr == `CDS_REG_CLEAR) ?
               i_wr_data[`CDS_EV_W-1:0] : '0;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ev_stat_r <= '0;
         ev_en_r   <= '0;
      end else begin
         ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
         if (i_wr && i_addr == `CDS_REG_ENABLE) begin
            ev_en_r <= i_wr_data[`CDS_EV_W-1:0];
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !i_rd) begin
         o_rd_data <= 32'h0;
      end else begin
         case (i_addr)
            `CDS_REG_STATUS: o_rd_data <= {28'h0, ev_stat_r};
            `CDS_REG_ENABLE: o_rd_data <= {28'h0, ev_en_r};
            `CDS_REG_STATE:  o_rd_data <= {24'h0, step_r, fault_r, deb_r,
                                           state_r};
            default:         o_rd_data <= 32'h0;
         endcase
      end
   end

   assign o_irq = |(ev_stat_r & ev_en_r);

   ////////////////////////////////////////////////////////////////////////
   // assertions

   property p_deact_entry;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_ACTIVE && sreq_n_s)
      |=> (state_r == cds_pkg::CDS_DEACT && !o_contacts.rst_en);
   endproperty
   a_deact_entry: assert property (p_deact_entry)
      else $error("deactivation did not start on request release");

   property p_clk_hold;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_DEACT && step_r == 4'h0 && half_tick)
      |=> (!o_contacts.clk_run && o_contacts.io_en && !o_contacts.rst_en);
   endproperty
   a_clk_hold: assert property (p_clk_hold)
      else $error("card clock not held low at half unit");

   property p_lines_low;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_DEACT)
      |-> (o_contacts.io_en == (step_r < 4'h2));
   endproperty
   a_lines_low: assert property (p_lines_low)
      else $error("card lines not low one unit after reset");

   property p_supply_off;
      @(posedge i_ref_clk) disable iff (i_reset)
      $fell(o_contacts.vcc_en) |-> (step_r == 4'h3 && $past(step_r) == 4'h2);
   endproperty
   a_supply_off: assert property (p_supply_off)
      else $error("card supply off at wrong step");

   property p_ground;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_DEACT && step_r == 4'ha)
      |-> (o_contacts.gnd && !o_contacts.boost_en && o_contacts.osc_fast);
   endproperty
   a_ground: assert property (p_ground)
      else $error("contacts not grounded at five units");

   property p_osc_slow;
      @(posedge i_ref_clk) disable iff (i_reset)
      $fell(o_contacts.osc_fast)
      |-> (state_r == cds_pkg::CDS_IDLE && $past(step_r) == 4'ha);
   endproperty
   a_osc_slow: assert property (p_osc_slow)
      else $error("oscillator slowed before final step");

   property p_ovl_filter;
      @(posedge i_ref_clk) disable iff (i_reset)
      ovl_flt |-> ($past(ovl_s) && $past(ovl_s, 2) && $past(ovl_s, 8));
   endproperty
   a_ovl_filter: assert property (p_ovl_filter)
      else $error("overload flagged on a short spike");

   property p_idle_status;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_IDLE && !fault_r && $stable(deb_r))
      |-> (o_fault_status_n == deb_r);
   endproperty
   a_idle_status: assert property (p_idle_status)
      else $error("status does not follow presence outside session");

   property p_por;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_IDLE && host_low_s && !host_low_d_r)
      |=> (o_por_pulse && $stable(o_fault_status_n)) ##1 !o_por_pulse;
   endproperty
   a_por: assert property (p_por)
      else $error("host supply drop handled wrongly outside session");

   property p_fault;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_ACTIVE && sess_fault)
      |=> (state_r == cds_pkg::CDS_DEACT && !o_fault_status_n);
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault did not start emergency deactivation");

   property p_insert;
      @(posedge i_ref_clk) disable iff (i_reset)
      $rose(o_fault_status_n) |-> (deb_r && $past(present_s, 8));
   endproperty
   a_insert: assert property (p_insert)
      else $error("status rose before debounce");

   property p_run_out;
      @(posedge i_ref_clk) disable iff (i_reset)
      (state_r == cds_pkg::CDS_DEACT && step_r != 4'ha)
      |=> (state_r == cds_pkg::CDS_DEACT);
   endproperty
   a_run_out: assert property (p_run_out)
      else $error("deactivation left before completion");

   c_normal_end: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      state_r == cds_pkg::CDS_DEACT && !fault_r
      ##1 state_r == cds_pkg::CDS_IDLE);
   c_fault_end: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      state_r == cds_pkg::CDS_ACTIVE ##1 fault_r);
   c_insert: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      $rose(o_fault_status_n));

endmodule : cds_supervisor

`default_nettype wire

// ### tb/cds_host_model.sv
// host controller and card contact model facing the supervisor
`timescale 1ns/1ps
`default_nettype none

module cds_host_model #(
   parameter int DISCHARGE_CYC = 200
) (
   // clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_reset,
   // scenario controls
   input  wire logic                   i_want_session,
   input  wire logic                   i_card_in,
   // device outputs
   input  wire logic                   i_fault_status_n,
   input  wire cds_pkg::cds_contacts_t i_contacts,
   // pins towards the device
   output logic                        o_session_request_n,
   output logic                        o_card_presence,
   output logic                        o_card_presence_n,
   output logic                        o_supply_inactive
);
   int unsigned dis_r;

   // request only while a card is reported, let go once a fault shows
   assign o_session_request_n = ~(i_want_session & i_fault_status_n);
   assign o_card_presence     = i_card_in;
   assign o_card_presence_n   = ~i_card_in;

   ////////////////////////////////////////////////////////////////////////
   // card supply capacitor needs time to drain after the supply is cut
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || i_contacts.vcc_en) begin
         dis_r <= 0;
      end else if (dis_r < DISCHARGE_CYC) begin
         dis_r <= dis_r + 1;
      end
   end
   assign o_supply_inactive = (dis_r >= DISCHARGE_CYC);
endmodule : cds_host_model

`default_nettype wire

// ### tb/cds_supervisor_tb.sv
// self-checking bench for the card deactivation and fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "cds_defs.svh"

`define CHK(nm, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
      end \
   end

module cds_supervisor_tb;
   localparam int         DEB    = 50;
   localparam int         HALF   = `CDS_HALF_UNIT_CYC;
   localparam logic [6:0] IDLE_C = 7'h02;
   localparam logic [6:0] ACT_C  = 7'h7d;
   // bench drives
   logic                   i_ref_clk         = 1'b0;
   logic                   i_reset           = 1'b1;
   logic                   want              = 1'b0;
   logic                   card_in           = 1'b0;
   logic                   i_supply_overload = 1'b0;
   logic                   i_host_supply_low = 1'b0;
   logic                   i_converter_fault = 1'b0;
   logic                   i_overheat        = 1'b0;
   logic [3:0]             i_addr            = 4'h0;
   logic [31:0]            i_wr_data         = 32'h0;
   logic                   i_wr              = 1'b0;
   logic                   i_rd              = 1'b0;
   // pins and outputs
   wire logic              req_n;
   wire logic              card_presence;
   wire logic              card_presence_n;
   wire logic              sup_inact;
   logic [31:0]            o_rd_data;
   cds_pkg::cds_contacts_t o_contacts;
   logic                   o_fault_status_n;
   logic                   o_por_pulse;
   logic                   o_irq;
   int                     miscompares = 0;
   int                     checks      = 0;

   always #4 i_ref_clk = ~i_ref_clk;

   cds_supervisor #(.DEBOUNCE_CYC(DEB)) i_cds_supervisor (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_session_request_n(req_n), .i_card_presence(card_presence),
      .i_card_presence_n(card_presence_n), .i_supply_overload(i_supply_overload),
      .i_host_supply_low(i_host_supply_low),
      .i_converter_fault(i_converter_fault), .i_overheat(i_overheat),
      .i_supply_inactive(sup_inact), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
      .o_rd_data(o_rd_data), .o_contacts(o_contacts),
      .o_fault_status_n(o_fault_status_n), .o_por_pulse(o_por_pulse),
      .o_irq(o_irq));

   cds_host_model i_cds_host_model (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_want_session(want),
      .i_card_in(card_in), .i_fault_status_n(o_fault_status_n),
      .i_contacts(o_contacts), .o_session_request_n(req_n),
      .o_card_presence(card_presence), .o_card_presence_n(card_presence_n),
      .o_supply_inactive(sup_inact));

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr      <= 1'b1;
      @(posedge i_ref_clk);
      i_wr      <= 1'b0;
      @(posedge i_ref_clk);
   endtask : reg_wr

   task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      #1;
      `CHK("register", e, o_rd_data)
      @(posedge i_ref_clk);
   endtask : chk_reg

   task automatic wait_ctc(input logic [6:0] c, output int n);
      n = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end while (o_contacts !== c && n < 20000);
   endtask : wait_ctc

   task automatic wait_stat(input logic v, output int n);
      n = 0;
      while (o_fault_status_n !== v && n < 5000) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
   endtask : wait_stat

   task automatic set_fault(input int f, input logic v);
      case (f)
         0: i_supply_overload <= v;
         1: i_host_supply_low <= v;
         2: i_converter_fault <= v;
         3: i_overheat        <= v;
         default: card_in     <= ~v;
      endcase
   endtask : set_fault

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK("contacts", IDLE_C, o_contacts)
      `CHK("status_n", 1'b0, o_fault_status_n)
      `CHK("irq", 1'b0, o_irq)
      reg_wr(`CDS_REG_STATUS, 32'hf);
      chk_reg(`CDS_REG_STATUS, 32'h0);
      chk_reg(`CDS_REG_CLEAR, 32'h0);
      chk_reg(4'h2, 32'h0);
      chk_reg(`CDS_REG_STATE, 32'h0);
   endtask : t_reset

   task automatic t_insert;
      int n;
      card_in <= 1'b1;
      wait_stat(1'b1, n);
      `CHK("debounce", 1'b1, n >= DEB && n <= DEB + 6)
      chk_reg(`CDS_REG_STATUS, 32'h4);
      reg_wr(`CDS_REG_ENABLE, 32'h4);
      #1;
      `CHK("irq on", 1'b1, o_irq)
      reg_wr(`CDS_REG_ENABLE, 32'h0);
      #1;
      `CHK("irq masked", 1'b0, o_irq)
      reg_wr(`CDS_REG_ENABLE, 32'h4);
      reg_wr(`CDS_REG_CLEAR, 32'h4);
      #1;
      `CHK("irq cleared", 1'b0, o_irq)
      chk_reg(`CDS_REG_ENABLE, 32'h4);
      chk_reg(`CDS_REG_STATUS, 32'h0);
   endtask : t_insert

   task automatic t_outside;
      int p;
      int bad;
      p   = 0;
      bad = 0;
      set_fault(1, 1'b1);
      set_fault(3, 1'b1);
      set_fault(0, 1'b1);
      repeat (3000) begin
         @(posedge i_ref_clk);
         #1;
         p += o_por_pulse;
         bad += (o_fault_status_n !== 1'b1);
      end
      `CHK("por pulses", 1, p)
      `CHK("status dips", 0, bad)
      `CHK("contacts", IDLE_C, o_contacts)
      for (int f = 0; f < 4; f++) set_fault(f, 1'b0);
      chk_reg(`CDS_REG_STATUS, 32'h0);
   endtask : t_outside

   task automatic t_normal;
      int n, tr, tc, ti, tv, tb, tg, to, rr;
      {tr, tc, ti, tv, tb, tg, to, rr} = '0;
      want <= 1'b1;
      wait_ctc(ACT_C, n);
      `CHK("active", ACT_C, o_contacts)
      want <= 1'b0;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         n++;
         if (n == 2000) want <= 1'b1;
         if (n == 2100) want <= 1'b0;
         if (tr != 0 && o_contacts.rst_en) rr++;
         if (tr == 0 && !o_contacts.rst_en) tr = n;
         if (tc == 0 && !o_contacts.clk_run) tc = n;
         if (ti == 0 && !o_contacts.io_en) ti = n;
         if (tv == 0 && !o_contacts.vcc_en) tv = n;
         if (tb == 0 && !o_contacts.boost_en) tb = n;
         if (tg == 0 && o_contacts.gnd) tg = n;
         if (to == 0 && !o_contacts.osc_fast) to = n;
      end while (o_contacts !== IDLE_C && n < 20000);
      `CHK("reset falls", 1'b1, tr >= 1 && tr <= 5)
      `CHK("clock hold", HALF, tc - tr)
      `CHK("lines low", 2 * HALF, ti - tr)
      `CHK("supply off", 3 * HALF, tv - tr)
      `CHK("boost off", 10 * HALF, tb - tr)
      `CHK("grounded", 10 * HALF, tg - tr)
      `CHK("osc slow last", 1'b1, to >= tg)
      `CHK("idle", IDLE_C, o_contacts)
      `CHK("no restart", 0, rr)
      chk_reg(`CDS_REG_STATUS, 32'h1);
      reg_wr(`CDS_REG_CLEAR, 32'hf);
   endtask : t_normal

   task automatic t_faults;
      int n;
      reg_wr(`CDS_REG_ENABLE, 32'h2);
      for (int f = 0; f < 5; f++) begin
         want <= 1'b1;
         wait_ctc(ACT_C, n);
         if (f == 0) begin
            set_fault(0, 1'b1);
            repeat (100) @(posedge i_ref_clk);
            set_fault(0, 1'b0);
            repeat (50) @(posedge i_ref_clk);
            #1;
            `CHK("spike", ACT_C, o_contacts)
         end
         set_fault(f, 1'b1);
         wait_stat(1'b0, n);
         `CHK("delay", 1'b1, f == 0 ? n >= 2500 && n <= 2510 : n <= 4)
         `CHK("rst low", 1'b0, o_contacts.rst_en)
         want <= 1'b0;
         if (f < 4) set_fault(f, 1'b0);
         wait_ctc(IDLE_C, n);
         wait_stat(f < 4, n);
         `CHK("status after", f < 4, o_fault_status_n)
      end
      chk_reg(`CDS_REG_STATUS, 32'hb);
      `CHK("fault irq", 1'b1, o_irq)
      reg_wr(`CDS_REG_CLEAR, 32'hf);
      #1;
      `CHK("irq cleared", 1'b0, o_irq)
   endtask : t_faults

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      t_reset;
      t_insert;
      t_outside;
      t_normal;
      t_faults;
      wrap_up;
   end

   initial begin
      repeat (140000) @(posedge i_ref_clk);
      miscompares++;
      wrap_up;
   end
endmodule : cds_supervisor_tb

`default_nettype wire
